/* rtl/mmt_pkg.sv */
// constants and types shared by the management two-wire target
`default_nettype none
package mmt_pkg;
    localparam logic [6:0] TARGET_ADDR        = 7'h50;
    localparam int         CLOCK_HZ           = 10_000_000;
    localparam int         STRETCH_MAX_US     = 500;
    localparam int         STRETCH_MAX_CYCLES = (STRETCH_MAX_US * (CLOCK_HZ / 1000)) / 1000;
    localparam int         STRETCH_W          = 13;
    localparam int         SYNC_STAGES        = 3;
    localparam logic [7:0] FILL_BYTE          = 8'hFF;
    localparam logic [7:0] BYTE_ADDR_RESET    = 8'h00;
    localparam logic [3:0] BITS_PER_WORD      = 4'h8;
    localparam logic [2:0] LAST_BIT           = 3'h7;

    typedef enum logic [2:0] {
        MMT_IDLE     = 3'b000,
        MMT_ADDR     = 3'b001,
        MMT_ADDR_ACK = 3'b010,
        MMT_WR_BYTE  = 3'b011,
        MMT_WR_ACK   = 3'b100,
        MMT_RD_LOAD  = 3'b101,
        MMT_RD_BYTE  = 3'b110,
        MMT_RD_ACK   = 3'b111
    } mmt_state_t;

    typedef struct packed {
        logic scl_i;
        logic sda_i;
        logic module_select_n;
    } mmt_pins_in_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } mmt_pins_out_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mmt_wr_t;

    typedef struct packed {
        mmt_state_t           fsm;
        logic [3:0]           bit_cnt;
        logic [7:0]           shift;
        logic                 rw;
        logic                 addr_loaded;
        logic [7:0]           byte_addr;
        logic                 sda_oe;
        logic                 scl_oe;
        logic [STRETCH_W-1:0] stretch_cnt;
        logic                 scl_q;
        logic                 sda_q;
        logic                 sel_n_q;
        mmt_wr_t              wr;
    } mmt_regs_t;
endpackage
`default_nettype wire

/* rtl/mmt_sync.sv */
// three-stage synchroniser for pins from outside the clock domain
`default_nettype none
module mmt_sync
    import mmt_pkg::*;
#(
    parameter int                WIDTH     = 3,
    parameter logic [WIDTH-1:0]  IDLE_LVL  = '1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] mid,
    output logic      [WIDTH-1:0] last
);
    logic [WIDTH-1:0] first;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first <= IDLE_LVL;
            mid   <= IDLE_LVL;
            last  <= IDLE_LVL;
        end else begin
            first <= din;
            mid   <= first;
            last  <= mid;
        end
    end
endmodule
`default_nettype wire

/* rtl/mmt_target.sv */
// two-wire management target: framing, addressing, ack, stretching, address counter
//
// Notes on behaviour
// - answer only target address 1010000 plus direction
// - deselected module ignores bus, never acknowledges
// - clock stretching released within 500 us
// - sample on rising, change after falling clock
// - module is target only; host clocks everything
// - data line pulled low or released only
// - data changes only while clock low
// - falling data high clock start; rising stop
// - eight-bit words, most significant bit first
// - receiver pulls data low for acknowledge bit
// - acknowledge every write data byte from host
// - recovery resets only this protocol state machine
// - first byte is address; bit0 one reads
// - matching address while selected gets low acknowledge
// - address counter advances, wraps within 128-byte page
// - repeated start after address load keeps counter
`default_nettype none
module mmt_target
    import mmt_pkg::*;
#(
    parameter int STRETCH_CYCLES = STRETCH_MAX_CYCLES
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire mmt_pins_in_t  pins_in,
    output mmt_pins_out_t      pins_out,
    output logic               rd_req,
    output logic [7:0]         rd_addr,
    input  wire logic          rd_valid,
    input  wire logic [7:0]    rd_data,
    output mmt_wr_t            wr,
    output logic [7:0]         byte_addr
);
    logic [1:0] rst_pipe;
    logic       rst_n;
    logic [2:0] sync_mid;
    logic [2:0] sync_last;
    mmt_regs_t  r;
    mmt_regs_t  next_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    mmt_sync #(
        .WIDTH    (3),
        .IDLE_LVL (3'h7)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   ({pins_in.scl_i, pins_in.sda_i, pins_in.module_select_n}),
        .mid   (sync_mid),
        .last  (sync_last)
    );

    function automatic logic [7:0] page_incr(input logic [7:0] a);
        page_incr = {a[7], a[6:0] + 7'h01};
    endfunction

    always_comb begin
        next_r          = r;
        next_r.wr.valid = 1'b0;
        if (sync_mid[2] == sync_last[2]) begin
            next_r.scl_q = sync_last[2];
        end
        if (sync_mid[1] == sync_last[1]) begin
            next_r.sda_q = sync_last[1];
        end
        if (sync_mid[0] == sync_last[0]) begin
            next_r.sel_n_q = sync_last[0];
        end
        scl_rise = !r.scl_q && next_r.scl_q;
        scl_fall = r.scl_q && !next_r.scl_q;
        start_c  = r.scl_q && next_r.scl_q && r.sda_q && !next_r.sda_q;
        stop_c   = r.scl_q && next_r.scl_q && !r.sda_q && next_r.sda_q;

        if (next_r.sel_n_q || stop_c) begin
            next_r.fsm    = MMT_IDLE;
            next_r.sda_oe = 1'b0;
            next_r.scl_oe = 1'b0;
        end else if (start_c) begin
            // start also serves as recovery: only protocol state is cleared
            next_r.fsm         = MMT_ADDR;
            next_r.bit_cnt     = 4'h0;
            next_r.sda_oe      = 1'b0;
            next_r.scl_oe      = 1'b0;
            next_r.addr_loaded = 1'b0;
        end else begin
            unique case (r.fsm)
                MMT_IDLE: begin
                end
                MMT_ADDR, MMT_WR_BYTE: begin
                    if (scl_rise && r.bit_cnt != BITS_PER_WORD) begin
                        next_r.shift   = {r.shift[6:0], next_r.sda_q};
                        next_r.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == BITS_PER_WORD) begin
                        if (r.fsm == MMT_ADDR) begin
                            if (r.shift[7:1] == TARGET_ADDR) begin
                                next_r.sda_oe = 1'b1;
                                next_r.rw     = r.shift[0];
                                next_r.fsm    = MMT_ADDR_ACK;
                            end else begin
                                next_r.fsm = MMT_IDLE;
                            end
                        end else begin
                            if (!r.addr_loaded) begin
                                next_r.byte_addr   = r.shift;
                                next_r.addr_loaded = 1'b1;
                            end else begin
                                next_r.wr.valid  = 1'b1;
                                next_r.wr.addr   = r.byte_addr;
                                next_r.wr.data   = r.shift;
                                next_r.byte_addr = page_incr(r.byte_addr);
                            end
                            next_r.sda_oe = 1'b1;
                            next_r.fsm    = MMT_WR_ACK;
                        end
                    end
                end
                MMT_ADDR_ACK, MMT_WR_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_oe  = 1'b0;
                        next_r.bit_cnt = 4'h0;
                        if (r.fsm == MMT_ADDR_ACK && r.rw) begin
                            next_r.fsm         = MMT_RD_LOAD;
                            next_r.scl_oe      = 1'b1;
                            next_r.stretch_cnt = '0;
                        end else begin
                            next_r.fsm = MMT_WR_BYTE;
                        end
                    end
                end
                MMT_RD_LOAD: begin
                    next_r.stretch_cnt = r.stretch_cnt + STRETCH_W'(1);
                    if (rd_valid || r.stretch_cnt == STRETCH_W'(STRETCH_CYCLES - 1)) begin
                        next_r.shift   = rd_valid ? rd_data : FILL_BYTE;
                        next_r.sda_oe  = rd_valid ? !rd_data[7] : !FILL_BYTE[7];
                        next_r.scl_oe  = 1'b0;
                        next_r.bit_cnt = 4'h0;
                        next_r.fsm     = MMT_RD_BYTE;
                    end
                end
                MMT_RD_BYTE: begin
                    if (scl_fall) begin
                        if (r.bit_cnt[2:0] == LAST_BIT) begin
                            next_r.sda_oe    = 1'b0;
                            next_r.fsm       = MMT_RD_ACK;
                            next_r.byte_addr = page_incr(r.byte_addr);
                        end else begin
                            next_r.bit_cnt = r.bit_cnt + 4'h1;
                            next_r.shift   = {r.shift[6:0], 1'b0};
                            next_r.sda_oe  = !r.shift[6];
                        end
                    end
                end
                MMT_RD_ACK: begin
                    if (scl_rise && next_r.sda_q) begin
                        next_r.fsm = MMT_IDLE;
                    end else if (scl_fall) begin
                        next_r.fsm         = MMT_RD_LOAD;
                        next_r.scl_oe      = 1'b1;
                        next_r.stretch_cnt = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r             <= '0;
            r.fsm         <= MMT_IDLE;
            r.byte_addr   <= BYTE_ADDR_RESET;
            r.scl_q       <= 1'b1;
            r.sda_q       <= 1'b1;
            r.sel_n_q     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pins_out.scl_o  = 1'b0;
    assign pins_out.sda_o  = 1'b0;
    assign pins_out.scl_oe = r.scl_oe;
    assign pins_out.sda_oe = r.sda_oe;
    assign rd_req          = (r.fsm == MMT_RD_LOAD);
    assign rd_addr         = r.byte_addr;
    assign wr              = r.wr;
    assign byte_addr       = r.byte_addr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_DESELECT_QUIET: assert property (r.sel_n_q |-> !r.sda_oe && !r.scl_oe)
        else $error("deselected target drives the bus");
    AST_STRETCH_BOUND: assert property (r.scl_oe |-> r.stretch_cnt < STRETCH_W'(STRETCH_CYCLES))
        else $error("clock held low too long");
    AST_CLOCK_HOLD_ONLY_LOAD: assert property (r.scl_oe |-> r.fsm == MMT_RD_LOAD)
        else $error("target holds the clock outside a read load");
    AST_DATA_ON_LOW: assert property ($changed(r.sda_oe) && !r.sel_n_q |-> !r.scl_q)
        else $error("data line changed while clock high");
    AST_ADDR_MATCH: assert property (r.fsm == MMT_ADDR_ACK && $past(r.fsm) == MMT_ADDR
                                     |-> $past(r.shift[7:1]) == TARGET_ADDR)
        else $error("acknowledged a foreign address");
    AST_ADDR_ACK_LOW: assert property (r.fsm == MMT_ADDR_ACK |-> r.sda_oe)
        else $error("address ack bit not driven low");
    AST_WRITE_ACK: assert property (r.fsm == MMT_WR_ACK |-> r.sda_oe)
        else $error("write byte not acknowledged");
    AST_PAGE_WRAP: assert property (r.wr.valid |-> r.byte_addr == {r.wr.addr[7], r.wr.addr[6:0] + 7'h01})
        else $error("address counter did not advance within page");
    AST_STOP_IDLE: assert property (stop_c |=> r.fsm == MMT_IDLE && !r.sda_oe && !r.scl_oe)
        else $error("stop did not idle the target");
    AST_RESTART_KEEPS_ADDR: assert property (start_c |=> r.byte_addr == $past(r.byte_addr))
        else $error("start changed the address counter");
    AST_MSB_FIRST: assert property (r.fsm == MMT_RD_BYTE |-> r.sda_oe == !r.shift[7])
        else $error("read bit does not follow shift msb");
    AST_READ_COUNT: assert property (r.fsm == MMT_RD_BYTE && $past(r.fsm) == MMT_RD_LOAD
                                     |-> r.bit_cnt == 4'h0)
        else $error("read byte does not start at msb");

    COV_WRITE: cover property (r.wr.valid);
    COV_READ_ACKED: cover property (r.fsm == MMT_RD_ACK ##[1:1000] r.fsm == MMT_RD_LOAD);
    COV_STRETCH_TIMEOUT: cover property (r.fsm == MMT_RD_LOAD && !rd_valid
                                         && r.stretch_cnt == STRETCH_W'(STRETCH_CYCLES - 1));
    COV_RESTART: cover property (r.fsm == MMT_WR_ACK ##[1:1000] start_c);
endmodule
`default_nettype wire

/* bench/mmt_host.sv */
// host bus master model for the two-wire target
`default_nettype none
module mmt_host (
    input  wire logic clock,
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_o,
    output var  logic sda_o,
    output var  logic sel_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        sel_n = 1'b1;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic select(input logic s, input int n);
        sel_n = s;
        hc(n);
    endtask
    // one bit, 800 ns period; waits while the target stretches
    task automatic bitx(input logic b, output logic r);
        hc(1);
        sda_o = b;
        hc(5);
        scl_o = 1'b1;
        for (int i = 0; i < 400 && scl !== 1'b1; i++) hc(1);
        r = sda;
        hc(2);
        scl_o = 1'b0;
    endtask
    task automatic start();
        hc(1);
        sda_o = 1'b1;
        hc(6);
        scl_o = 1'b1;
        hc(4);
        sda_o = 1'b0;
        hc(4);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        hc(1);
        sda_o = 1'b0;
        hc(6);
        scl_o = 1'b1;
        hc(4);
        sda_o = 1'b1;
        hc(210);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(~ack, r);
    endtask
endmodule
`default_nettype wire

/* bench/mmt_target_test.sv */
// self-checking bench for the management two-wire target
`default_nettype none
module mmt_target_test
    import mmt_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic          clock = 1'b0;
    logic          reset_n = 1'b0;
    logic          rd_valid = 1'b0;
    logic [7:0]    rd_data = 8'h00;
    logic          mute = 1'b0;
    logic          rd_req_q = 1'b0;
    logic          h_scl, h_sda, h_sel_n, rd_req, ack, r;
    wire logic     scl, sda;
    mmt_pins_out_t pins_out;
    mmt_wr_t       wr;
    logic [7:0]    rd_addr, byte_addr, a, d;
    logic [15:0]   wq[$], rq[$];
    int            failures = 0, n_checks = 0, seed = 32'h8E12B717;
    assign scl = h_scl & (pins_out.scl_oe ? pins_out.scl_o : 1'b1);
    assign sda = h_sda & (pins_out.sda_oe ? pins_out.sda_o : 1'b1);
    always #50 clock = ~clock;
    mmt_host host (.clock(clock), .scl(scl), .sda(sda), .scl_o(h_scl), .sda_o(h_sda), .sel_n(h_sel_n));
    mmt_target #(.STRETCH_CYCLES(20)) dut (.clock(clock), .reset_n(reset_n),
        .pins_in(mmt_pins_in_t'({scl, sda, h_sel_n})),
        .pins_out(pins_out), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr(wr), .byte_addr(byte_addr));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        check(16'(wq.size() + rq.size()), 16'h0000);
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[7], v[6:0] + 7'h01};
    endfunction
    // user read port and result watcher
    always @(negedge clock) begin
        rd_valid <= rd_req & ~mute;
        rd_data  <= rd_addr ^ 8'h5A;
        if (wr.valid === 1'b1) check({wr.addr, wr.data}, wq.size() ? wq.pop_front() : 16'hXXXX);
        if (rd_req === 1'b1 && rd_req_q !== 1'b1) check({8'h00, rd_addr}, rq.size() ? rq.pop_front() : 16'hXXXX);
        rd_req_q <= rd_req;
    end
    initial begin
        #9_000_000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        host.select(1'b0, 20000);
        a = 8'hFD;
        host.start();
        host.wbyte(8'hA0, ack);
        check(ack, 1);
        host.wbyte(a, ack);
        check(ack, 1);
        repeat (4) begin
            d = 8'($random(seed));
            wq.push_back({a, d});
            host.wbyte(d, ack);
            check(ack, 1);
            a = nx(a);
        end
        host.stop();
        check(byte_addr, a);
        host.start();
        host.wbyte(8'hA0, ack);
        host.wbyte(8'h10, ack);
        host.start();
        host.wbyte(8'hA1, ack);
        check(ack, 1);
        for (int i = 0; i < 2; i++) begin
            rq.push_back(16'(16'h0010 + i));
            host.rbyte(i == 0, d);
            check(d, 8'h4A ^ i[7:0]);
        end
        host.stop();
        check(byte_addr, 8'h12);
        mute = 1'b1;
        host.start();
        host.wbyte(8'hA1, ack);
        rq.push_back(16'h0012);
        host.rbyte(1'b0, d);
        check(d, FILL_BYTE);
        host.stop();
        mute = 1'b0;
        repeat (4) begin
            d = 8'($random(seed));
            if (d[7:1] == TARGET_ADDR) d[1] = ~d[1];
            host.start();
            host.wbyte(d, ack);
            check(ack, 0);
            host.stop();
        end
        host.start();
        host.wbyte(8'hA0, ack);
        host.select(1'b1, 1);
        host.wbyte(8'h33, ack);
        check(ack, 0);
        check(pins_out.sda_oe, 0);
        host.stop();
        host.start();
        host.wbyte(8'hA0, ack);
        check(ack, 0);
        host.stop();
        host.select(1'b0, 20000);
        host.start();
        for (int i = 0; i < 4; i++) host.bitx(~i[0], r);
        for (int i = 0; i < 9; i++) begin
            host.bitx(1'b1, r);
            check(r, 1);
        end
        host.start();
        host.wbyte(8'hA1, ack);
        check(ack, 1);
        rq.push_back(16'h0013);
        host.rbyte(1'b0, d);
        check(d, 8'h49);
        host.stop();
        check(byte_addr, 8'h14);
        finish_test();
    end
endmodule
`default_nettype wire
